// *** core/sbpr_ctl.sv ***
// SDRAM command decode, burst column order, auto and explicit precharge,
// self refresh, power down and clock suspend tracking.
// Assumes link pins are asynchronous to ref_clk_in; link clock sampled.
// Functional notes
// - Sequential burst increments column, wrapping within burst window bits.
// - Interleave burst XORs start column low bits with word index.
// - Address bit 10 high on read or write adds auto precharge, except on full-page writes.
// - Read auto precharge starts CAS-latency-dependent clocks before burst end.
// - Write auto precharge starts two clocks after last write word.
// - CS, RAS, WE low with CAS high decodes precharge.
// - Precharge uses bit 10 and bank selects to choose banks.
// - CS, RAS, CAS, CKE low with WE high enters self refresh.
// - Self refresh ignores all but CKE; leaves once CKE is high.
// - CKE low enters power down; leaves once CKE is high at a link clock edge.
// - CS low with others high is no-operation; bursts continue.
// - CS high is deselect, same as no-operation.
// - Burst type and length come from the mode settings.
// - CKE low during a burst gives clock suspend, not power down.
`timescale 1ns/1ps
`include "sbpr_defs.svh"
module sbpr_ctl (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Link pins
  input wire logic link_clk_in,
  input wire sbpr_pkg::sbpr_pins_t pins_in,
  // Register port
  input wire logic [`SBPR_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Core side
  output logic [8:0] col_out,
  output logic col_valid_out,
  output logic burst_write_out,
  output logic [1:0] bank_out,
  output logic [3:0] precharge_out,
  output logic [3:0] bank_open_out,
  output logic self_refresh_out,
  output logic power_down_out,
  output logic clock_suspend_out
);
  sbpr_pkg::sbpr_regs_t r;
  sbpr_pkg::sbpr_regs_t n;

  function automatic logic [9:0] words(input logic [2:0] b);
    case (b)
      `SBPR_BL_1: words = `SBPR_W_1;
      `SBPR_BL_2: words = `SBPR_W_2;
      `SBPR_BL_4: words = `SBPR_W_4;
      `SBPR_BL_8: words = `SBPR_W_8;
      default: words = `SBPR_W_FULL;
    endcase
  endfunction

  function automatic logic [8:0] col_of(input logic [8:0] s, input logic [9:0] c,
                                        input logic il, input logic [8:0] m);
    if (il) begin
      col_of = s ^ (c[8:0] & m);
    end else begin
      col_of = (s & ~m) | (9'(s + c[8:0]) & m);
    end
  endfunction

  logic e;
  logic cmd_ok;
  logic [9:0] blw;
  logic [8:0] mask;
  logic full;
  logic is_nop;
  logic is_pre;
  logic is_sr;
  logic [3:0] pre_mask;

  assign e = r.lc2 & ~r.lcp;
  assign cmd_ok = e & r.cke_prev;
  assign blw = words(r.burst_length_setting);
  assign mask = 9'(blw - 10'h001);
  assign full = r.burst_length_setting == `SBPR_BL_FULL;
  assign is_nop = r.p2.cs_n | (r.p2.ras_n & r.p2.cas_n & r.p2.we_n);
  assign is_pre = !r.p2.cs_n && !r.p2.ras_n && r.p2.cas_n && !r.p2.we_n;
  assign is_sr = !r.p2.cs_n && !r.p2.ras_n && !r.p2.cas_n && r.p2.we_n && !r.p2.cke;
  assign pre_mask = r.p2.addr[`SBPR_AP_BIT] ? 4'hF :
                    4'(4'h1 << {r.p2.bank_select_high, r.p2.bank_select_low});

  always_comb begin
    logic [9:0] nc;
    logic [10:0] nsum;
    nc = 10'h000;
    nsum = 11'h000;
    n = r;
    n.p1 = pins_in;
    n.p2 = r.p1;
    n.lc1 = link_clk_in;
    n.lc2 = r.lc1;
    n.lcp = r.lc2;
    n.prech = 4'h0;
    n.col_vld = 1'b0;
    n.rdata = 32'h0000_0000;
    if (reg_wr_in && reg_addr_in == `SBPR_OFS_CFG) begin
      n.burst_length_setting = reg_wdata_in[`SBPR_CFG_BL];
      n.il = reg_wdata_in[`SBPR_CFG_IL];
      n.cl = reg_wdata_in[`SBPR_CFG_CL];
    end
    if (reg_rd_in && reg_addr_in == `SBPR_OFS_CFG) begin
      n.rdata[`SBPR_CFG_BL] = r.burst_length_setting;
      n.rdata[`SBPR_CFG_IL] = r.il;
      n.rdata[`SBPR_CFG_CL] = r.cl;
    end else if (reg_rd_in && reg_addr_in == `SBPR_OFS_STAT) begin
      n.rdata = {9'h000, r.state, r.open, r.bank, r.wr, r.ap, r.cnt, 2'h0};
    end
    if (e) begin
      n.cke_prev = r.p2.cke;
    end
    case (r.state)
      sbpr_pkg::ST_SELF: begin
        if (r.p2.cke) begin
          n.state = sbpr_pkg::ST_IDLE;
        end
      end
      sbpr_pkg::ST_PDOWN: begin
        if (e && r.p2.cke) begin
          n.state = sbpr_pkg::ST_IDLE;
        end
      end
      sbpr_pkg::ST_SUSP: begin
        if (e && r.p2.cke) begin
          n.state = sbpr_pkg::ST_BURST;
        end
      end
      sbpr_pkg::ST_IDLE, sbpr_pkg::ST_BURST: begin
        if (cmd_ok && r.state == sbpr_pkg::ST_BURST) begin
          // Advance one word; a no-operation leaves this running
          nc = r.cnt + 10'h001;
          if (full) begin
            nc[9] = 1'b0;
          end
          n.cnt = nc;
          if (full || nc < blw) begin
            n.col_vld = 1'b1;
            n.col = col_of(r.start, nc, r.il, mask);
          end
          nsum = {1'b0, nc} + {8'h00, r.cl};
          if (r.ap && !r.ap_done &&
              (r.wr ? {1'b0, nc} == {1'b0, blw} + 11'h001 : nsum >= {1'b0, blw})) begin
            n.prech = 4'(4'h1 << r.bank);
            n.open = r.open & ~n.prech;
            n.ap_done = 1'b1;
          end
          if (!full && nc >= blw && (!r.ap || !r.wr || nc > blw)) begin
            n.state = sbpr_pkg::ST_IDLE;
          end
        end
        if (cmd_ok && !r.p2.cke) begin
          if (is_sr && r.state == sbpr_pkg::ST_IDLE) begin
            n.state = sbpr_pkg::ST_SELF;
          end else if (r.state == sbpr_pkg::ST_BURST) begin
            n.state = sbpr_pkg::ST_SUSP;
          end else begin
            n.state = sbpr_pkg::ST_PDOWN;
          end
        end else if (cmd_ok && !is_nop) begin
          if (!r.p2.ras_n && r.p2.cas_n && r.p2.we_n) begin
            n.open = n.open | 4'(4'h1 << {r.p2.bank_select_high, r.p2.bank_select_low});
          end else if (r.p2.ras_n && !r.p2.cas_n) begin
            n.state = sbpr_pkg::ST_BURST;
            n.start = r.p2.addr[`SBPR_COL_MSB:0];
            n.cnt = 10'h000;
            n.wr = !r.p2.we_n;
            n.ap = r.p2.addr[`SBPR_AP_BIT];
            n.ap_done = 1'b0;
            n.bank = {r.p2.bank_select_high, r.p2.bank_select_low};
            n.col = r.p2.addr[`SBPR_COL_MSB:0];
            n.col_vld = 1'b1;
          end else if (is_pre) begin
            n.prech = n.prech | pre_mask;
            n.open = n.open & ~pre_mask;
          end else if (r.p2.ras_n && r.p2.cas_n && !r.p2.we_n) begin
            n.state = sbpr_pkg::ST_IDLE;
          end
        end
      end
      default: n.state = sbpr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      r <= '0;
      r.burst_length_setting <= `SBPR_BL_RST;
      r.cl <= `SBPR_CL_RST;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata_out = r.rdata;
  assign col_out = r.col;
  assign col_valid_out = r.col_vld;
  assign burst_write_out = r.wr;
  assign bank_out = r.bank;
  assign precharge_out = r.prech;
  assign bank_open_out = r.open;
  assign self_refresh_out = r.state == sbpr_pkg::ST_SELF;
  assign power_down_out = r.state == sbpr_pkg::ST_PDOWN;
  assign clock_suspend_out = r.state == sbpr_pkg::ST_SUSP;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic live;
  logic [1:0] bank_sel;
  assign live = cmd_ok && r.p2.cke;
  assign bank_sel = {r.p2.bank_select_high, r.p2.bank_select_low};

  property p_pre_all;
    live && is_pre && r.p2.addr[`SBPR_AP_BIT] |=> precharge_out == 4'hF;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("all-bank precharge missed");

  property p_pre_one;
    live && is_pre && !r.p2.addr[`SBPR_AP_BIT] |=>
      precharge_out[$past(bank_sel)] && !bank_open_out[$past(bank_sel)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("bank precharge missed");

  property p_sr_in;
    cmd_ok && is_sr && r.state == sbpr_pkg::ST_IDLE |=> self_refresh_out;
  endproperty
  a_sr_in: assert property (p_sr_in) else $error("self refresh not entered");

  property p_sr_hold;
    self_refresh_out && !r.p2.cke |=> self_refresh_out && $stable(bank_open_out);
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("self refresh left early");

  property p_sr_out;
    self_refresh_out && r.p2.cke |=> !self_refresh_out;
  endproperty
  a_sr_out: assert property (p_sr_out) else $error("self refresh not left");

  property p_pd;
    cmd_ok && !r.p2.cke && !is_sr && r.state == sbpr_pkg::ST_IDLE |=> power_down_out;
  endproperty
  a_pd: assert property (p_pd) else $error("power down missed");

  property p_susp;
    cmd_ok && !r.p2.cke && r.state == sbpr_pkg::ST_BURST |=> clock_suspend_out;
  endproperty
  a_susp: assert property (p_susp) else $error("clock suspend missed");

  property p_nop;
    live && is_nop && r.state == sbpr_pkg::ST_BURST && r.cnt == 10'h000 && blw > 10'h002
      |=> r.state == sbpr_pkg::ST_BURST && col_valid_out;
  endproperty
  a_nop: assert property (p_nop) else $error("burst ended by no-operation");

  property p_seq;
    col_valid_out && !r.il |-> (col_out & ~mask) == (r.start & ~mask);
  endproperty
  a_seq: assert property (p_seq) else $error("sequential carry escaped window");

  property p_il;
    col_valid_out && r.il |-> col_out == (r.start ^ (r.cnt[8:0] & mask));
  endproperty
  a_il: assert property (p_il) else $error("interleave column wrong");

  property p_wr_ap;
    live && is_nop && r.state == sbpr_pkg::ST_BURST && r.wr && r.ap && !full &&
      r.cnt == blw |=> precharge_out != 4'h0;
  endproperty
  a_wr_ap: assert property (p_wr_ap) else $error("write auto precharge late");

  property p_rd_ap;
    live && is_nop && r.state == sbpr_pkg::ST_BURST && !r.wr && r.ap && !r.ap_done &&
      !full && ({1'b0, r.cnt} + 11'h001 + {8'h00, r.cl}) >= {1'b0, blw}
      |=> precharge_out != 4'h0;
  endproperty
  a_rd_ap: assert property (p_rd_ap) else $error("read auto precharge late");

  c_ap: cover property (precharge_out != 4'h0 && r.ap);
  c_sr: cover property (self_refresh_out ##1 !self_refresh_out);
  c_susp: cover property (clock_suspend_out ##1 r.state == sbpr_pkg::ST_BURST);
  c_il: cover property (col_valid_out && r.il && r.cnt == 10'h005);
endmodule // sbpr_ctl

// *** core/sbpr_defs.svh ***
// Constants of the SDRAM command-side block.
// Assumes inclusion by bare name wherever needed.
`ifndef SBPR_DEFS_SVH
`define SBPR_DEFS_SVH
// Register port
`define SBPR_ADDR_W 4
`define SBPR_OFS_CFG 4'h0
`define SBPR_OFS_STAT 4'h4
// Config fields
`define SBPR_CFG_BL 2:0
`define SBPR_CFG_IL 3
`define SBPR_CFG_CL 6:4
// Burst length codes
`define SBPR_BL_1 3'h0
`define SBPR_BL_2 3'h1
`define SBPR_BL_4 3'h2
`define SBPR_BL_8 3'h3
`define SBPR_BL_FULL 3'h7
// Words per burst
`define SBPR_W_1 10'h001
`define SBPR_W_2 10'h002
`define SBPR_W_4 10'h004
`define SBPR_W_8 10'h008
`define SBPR_W_FULL 10'h200
// Reset values
`define SBPR_BL_RST 3'h3
`define SBPR_CL_RST 3'h3
// Address bit selecting auto precharge / all banks
`define SBPR_AP_BIT 10
`define SBPR_COL_MSB 8
`endif

// *** core/sbpr_pkg.sv ***
// Types of the SDRAM command-side block.
// Assumes sbpr_defs.svh for numeric constants.
package sbpr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_BURST = 3'b001,
    ST_SELF  = 3'b010,
    ST_PDOWN = 3'b011,
    ST_SUSP  = 3'b100
  } sbpr_st_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_high;
    logic bank_select_low;
    logic [11:0] addr;
  } sbpr_pins_t;

  typedef struct packed {
    sbpr_pins_t p1;
    sbpr_pins_t p2;
    logic lc1;
    logic lc2;
    logic lcp;
    logic cke_prev;
    sbpr_st_t state;
    logic [3:0] open;
    logic wr;
    logic ap;
    logic ap_done;
    logic [1:0] bank;
    logic [8:0] start;
    logic [9:0] cnt;
    logic [3:0] prech;
    logic [8:0] col;
    logic col_vld;
    logic [2:0] burst_length_setting;
    logic il;
    logic [2:0] cl;
    logic [31:0] rdata;
  } sbpr_regs_t;
endpackage

// *** testbench/sbpr_ctl_test.sv ***
// Testbench of the SDRAM command-side block: bursts, precharge, low-power states.
// Assumes sbpr_link_model as the controller on the link side.
`timescale 1ns/1ps
module sbpr_ctl_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic link_clk;
  sbpr_pkg::sbpr_pins_t pins;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rdata;
  logic [8:0] col;
  logic col_vld, bwr, sref, pdn, susp;
  logic [1:0] bank, b, bl;
  logic [3:0] pre, open_b;
  logic [8:0] s;
  logic il, ap, w;
  logic [31:0] exp_rd[$], exp_col[$], exp_pre[$];
  int seed = 17535;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  always #2 ref_clk = ~ref_clk;

  sbpr_link_model u_link (.link_clk_out(link_clk), .pins_out(pins));

  sbpr_ctl u_dut (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .link_clk_in(link_clk), .pins_in(pins),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .col_out(col), .col_valid_out(col_vld), .burst_write_out(bwr), .bank_out(bank),
    .precharge_out(pre), .bank_open_out(open_b), .self_refresh_out(sref),
    .power_down_out(pdn), .clock_suspend_out(susp)
  );

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    return q.size() != 0 ? q.pop_front() : 32'hX;
  endfunction

  function automatic logic [8:0] ecol(logic [8:0] st, logic [8:0] k, logic lv, logic [8:0] msk);
    return lv ? (st ^ k) : ((st & ~msk) | ((st + k) & msk));
  endfunction

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask

  task automatic finish_test;
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Monitor: oldest note against each result
  always @(posedge ref_clk) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d) chk("rdata", pop(exp_rd), rdata);
    if (col_vld) chk("column", pop(exp_col), {20'h0, bwr, bank, col});
    if (pre != 4'h0) chk("precharge", pop(exp_pre), 32'(pre));
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_rd(4'h0, 32'h33);
    reg_rd(4'h8, 32'h0);
    // Lengths 1..8 in both orders, then read and write with auto precharge
    for (int m = 0; m < 10; m++) begin
      bl = (m < 8) ? m[2:1] : 2'h2;
      il = m[0] & (m < 8);
      ap = (m >= 8);
      w = (m < 8) ? 1'($random(seed)) : m[0];
      s = 9'($random(seed));
      b = 2'($random(seed));
      reg_wr(4'h0, {25'h0, 3'h3, il, 1'b0, bl});
      reg_rd(4'h0, {25'h0, 3'h3, il, 1'b0, bl});
      u_link.cmd(1'b1, 4'b0011, b, 12'h000);
      chk("open", 32'(4'h1 << b), 32'(open_b));
      for (int k = 0; k < (1 << bl); k++)
        exp_col.push_back(32'({w, b, ecol(s, k[8:0], il, 9'((1 << bl) - 1))}));
      if (ap) exp_pre.push_back(32'(4'h1 << b));
      // Auto precharge only on the last two passes, read then write, length 4
      u_link.cmd(1'b1, {3'b010, ~w}, b, {1'b0, ap, 1'b0, s});
      u_link.idle(12); // Burst and recovery drain first
      if (!ap) begin
        exp_pre.push_back(m[1] ? 32'hF : 32'(4'h1 << b));
        u_link.cmd(1'b1, 4'b0010, b, {1'b0, m[1], 10'h000});
        u_link.idle(2);
      end
      chk("open", 32'h0, 32'(open_b));
    end
    // Status after a write with auto precharge: idle, banks closed, word count 5
    reg_rd(4'h4, {9'h000, 3'h0, 4'h0, b, 2'b11, 10'h005, 2'h0});
    // Short refresh burst before self refresh
    repeat (4) u_link.cmd(1'b1, 4'b0001, 2'h0, 12'h000);
    // Self refresh, with an ignored read inside
    u_link.cmd(1'b0, 4'b0001, 2'h0, 12'h000);
    chk("self", 32'h1, 32'(sref));
    u_link.cmd(1'b0, 4'b0101, 2'h0, 12'h000);
    chk("self", 32'h1, 32'(sref));
    u_link.cmd(1'b1, 4'b0111, 2'h0, 12'h000);
    chk("self", 32'h0, 32'(sref));
    u_link.idle(4);
    repeat (4) u_link.cmd(1'b1, 4'b0001, 2'h0, 12'h000);
    // Power down, with an ignored read inside
    u_link.cmd(1'b0, 4'b1111, 2'h0, 12'h000);
    chk("pdown", 32'h1, 32'(pdn));
    u_link.cmd(1'b0, 4'b0101, 2'h0, 12'h000);
    u_link.cmd(1'b1, 4'b0111, 2'h0, 12'h000);
    chk("pdown", 32'h0, 32'(pdn));
    u_link.idle(2);
    // CKE low inside a burst suspends it
    reg_wr(4'h0, 32'h33);
    s = 9'($random(seed));
    u_link.cmd(1'b1, 4'b0011, 2'h1, 12'h000);
    for (int k = 0; k < 8; k++) exp_col.push_back(32'({3'b001, ecol(s, k[8:0], 1'b0, 9'h007)}));
    u_link.cmd(1'b1, 4'b0101, 2'h1, {3'b000, s});
    u_link.cmd(1'b0, 4'b1111, 2'h0, 12'h000);
    chk("suspend", 32'h1, 32'(susp));
    chk("pdown", 32'h0, 32'(pdn));
    u_link.cmd(1'b1, 4'b0111, 2'h0, 12'h000);
    u_link.idle(12);
    chk("leftover", 32'h0, 32'(exp_col.size() + exp_pre.size() + exp_rd.size()));
    finish_test();
  end
endmodule // sbpr_ctl_test

// *** testbench/sbpr_link_model.sv ***
// Memory controller model: free-running link clock and command pins.
// Assumes the testbench sequences commands through cmd and idle.
`timescale 1ns/1ps
module sbpr_link_model (
  // Link side
  output logic link_clk_out,
  output sbpr_pkg::sbpr_pins_t pins_out
);
  initial begin
    link_clk_out = 1'b0;
    pins_out = {1'b1, 4'b1111, 2'h0, 12'h000};
  end

  always #62.5 link_clk_out = ~link_clk_out;

  // Lines launched at the falling edge, stable across the rising edge
  task automatic cmd(input logic cke, input logic [3:0] csrw, input logic [1:0] b, input logic [11:0] a);
    @(negedge link_clk_out);
    pins_out <= {cke, csrw, b, a};
    idle(1);
  endtask

  // Deselect keeps CKE and holds CS high, other lines toggle every cycle
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge link_clk_out);
      pins_out <= {pins_out.cke, 1'b1, ~pins_out.ras_n, ~pins_out.cas_n, ~pins_out.we_n,
                   ~pins_out.bank_select_high, ~pins_out.bank_select_low, ~pins_out.addr};
    end
  endtask
endmodule // sbpr_link_model
